// file: bench/fag_host_model.sv
// partner model: firmware and debug-port request source
module fag_host_model
  import fag_pkg::*;
(
  input  wire logic   clk_in,
  output logic        fw_req_out,
  output logic [1:0]  fw_op_out,
  output logic [15:0] fw_addr_out,
  output logic [15:0] fw_pc_out,
  output logic        fw_scratch_out,
  output logic        wr_en_out,
  output logic        er_en_out,
  output logic        dbg_req_out,
  output logic [1:0]  dbg_op_out,
  output logic [15:0] dbg_addr_out,
  output logic        irq_out,
  output logic        rst_src_wr_out
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    {fw_req_out, fw_op_out, fw_addr_out, fw_pc_out, fw_scratch_out} = '0;
    {wr_en_out, er_en_out, dbg_req_out, dbg_op_out, dbg_addr_out} = '0;
    {irq_out, rst_src_wr_out} = '0;
  end
  // ==========================================
  // request tasks
  task automatic fw(input logic [1:0] op, input logic [15:0] a, input logic [15:0] pc,
                    input logic sc, input logic we, input logic ee);
    // runs on the one bench clock, i.e. the internal oscillator
    @(posedge clk_in);
    {fw_req_out, fw_op_out, fw_addr_out, fw_pc_out} <= {1'b1, op, a, pc};
    {fw_scratch_out, wr_en_out, er_en_out} <= {sc, we, ee};
    @(posedge clk_in);
    {fw_req_out, fw_addr_out, fw_pc_out} <= {1'b0, ~a, ~pc};
    {wr_en_out, er_en_out} <= 2'h0;
  endtask
  task automatic dbg(input logic [1:0] op, input logic [15:0] a);
    @(posedge clk_in);
    {dbg_req_out, dbg_op_out, dbg_addr_out} <= {1'b1, op, a};
    @(posedge clk_in);
    {dbg_req_out, dbg_addr_out} <= {1'b0, ~a};
  endtask
  // whole-register write, flash error flag cleared
  task automatic clr_flag();
    @(posedge clk_in);
    rst_src_wr_out <= 1'b1;
    @(posedge clk_in);
    rst_src_wr_out <= 1'b0;
  endtask
  task automatic post_irq();
    @(posedge clk_in);
    irq_out <= 1'b1;
    @(posedge clk_in);
    irq_out <= 1'b0;
  endtask
endmodule // fag_host_model

// file: bench/testbench.sv
// testbench: flash access guard scenarios
module testbench;
  import fag_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic       clk = 0, srst = 0, por = 0, dev_erase = 0, skip = 0;
  logic       vm_en = 1, vm_ren = 1, vm_wr = 0, vm_en_wr = 0, vm_ren_wr = 0;
  logic [7:0] lock_byte = 8'hff;
  logic       req, sc, we, ee, dreq, irq, rs_wr;
  logic [1:0] op, dop;
  logic [15:0] addr, pc, daddr;
  logic       permit, dpermit, err, flag, vm_o, vmr_o, perase, bwrite, eall;
  logic       lwr, pid, sense, rowc, ipend, busy;
  logic [7:0] leff;
  int         bad_count = 0, cmp_count = 0, cyc = 0, ea_cnt = 0, seen;
  initial forever #5 clk = ~clk;
  fag_host_model host (.clk_in(clk), .fw_req_out(req), .fw_op_out(op), .fw_addr_out(addr),
    .fw_pc_out(pc), .fw_scratch_out(sc), .wr_en_out(we), .er_en_out(ee),
    .dbg_req_out(dreq), .dbg_op_out(dop), .dbg_addr_out(daddr), .irq_out(irq),
    .rst_src_wr_out(rs_wr));
  flash_access_guard dut (.clk_in(clk), .srst_in(srst), .por_in(por), .fw_req_in(req),
    .fw_op_in(op), .fw_addr_in(addr), .fw_pc_in(pc), .fw_scratch_in(sc),
    .flash_write_enable_bit_in(we), .flash_erase_enable_bit_in(ee), .vmon_en_in(vm_en),
    .vmon_rst_en_in(vm_ren), .vmon_wr_in(vm_wr), .vmon_en_wr_in(vm_en_wr),
    .vmon_rst_en_wr_in(vm_ren_wr), .dbg_req_in(dreq), .dbg_op_in(dop), .dbg_addr_in(daddr),
    .debug_port_device_erase_in(dev_erase), .lock_byte_in(lock_byte), .skip_bit_in(skip),
    .irq_in(irq), .rst_src_wr_in(rs_wr), .permit_out(permit), .dbg_permit_out(dpermit),
    .flash_error_reset_out(err), .flash_error_flag_out(flag), .vmon_en_out(vm_o),
    .vmon_rst_en_out(vmr_o), .page_erase_out(perase), .byte_write_out(bwrite),
    .erase_all_out(eall), .lock_wr_out(lwr), .part_id_read_out(pid), .sense_en_out(sense),
    .row_change_out(rowc), .irq_pending_out(ipend), .busy_out(busy), .lock_eff_out(leff));
  // ==========================================
  // helpers
  task automatic conclude();
    $display("mismatches %0d of %0d comparisons", bad_count, cmp_count);
    if (bad_count == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (eall === 1'b1) ea_cnt++;
    if (cyc == 3000) begin
      bad_count++;
      conclude();
    end
  end
  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic rst(input logic p, input logic [7:0] lb);
    @(posedge clk);
    {srst, por, lock_byte} <= {1'b1, p, lb};
    repeat (6) @(posedge clk);
    {srst, por} <= 2'h0;
    @(posedge clk);
    #1;
  endtask
  task automatic fwc(input logic [1:0] o, input logic [15:0] a, input logic [15:0] p,
                     input logic s, input logic w, input logic e, input logic ok);
    host.fw(o, a, p, s, w, e);
    #1;
    chk("permit", ok ? 8'h1 : 8'h0, permit);
    chk("error reset", ok ? 8'h0 : 8'h1, err);
  endtask
  task automatic dbc(input logic [1:0] o, input logic [15:0] a, input logic ok);
    host.dbg(o, a);
    #1;
    chk("debug permit", ok ? 8'h1 : 8'h0, dpermit);
    chk("error reset", 8'h0, err);
  endtask
  // ==========================================
  // scenarios
  initial begin
    rst(1'b1, 8'hff);
    chk("monitor enables", 8'h3, {vm_o, vmr_o});
    chk("flag", 8'h0, flag);
    fwc(OP_READ, 16'h0000, 16'h0400, 0, 0, 0, 1);
    fwc(OP_WRITE, 16'h1234, 16'h0400, 0, 1, 0, 1);
    chk("byte write", 8'h1, bwrite);
    fwc(OP_ERASE, 16'h1234, 16'h0400, 0, 1, 1, 1);
    chk("page erase", 8'h1, perase);
    fwc(OP_WRITE, 16'hfc00, 16'h0400, 0, 1, 0, 0);
    chk("flag", 8'h1, flag);
    host.clr_flag();
    #1;
    chk("flag", 8'h0, flag);
    dbc(OP_ERASE, 16'hfc00, 0);
    dbc(OP_WRITE, 16'h0400, 1);
    fwc(OP_READ, PART_ID_ADDR, 16'h0400, 0, 0, 0, 1);
    chk("part id read", 8'h1, pid);
    for (int i = 0; i < 2; i++) begin
      @(posedge clk);
      {vm_en, vm_ren, vm_en_wr, vm_ren_wr} <= {2'h0, i == 0, i == 1};
      @(posedge clk);
      {vm_en_wr, vm_ren_wr} <= 2'h0;
      #1;
      chk("monitor enables", i == 0 ? 8'h1 : 8'h2, {vm_o, vmr_o});
      fwc(OP_WRITE, 16'h1234, 16'h0400, 0, 1, 0, 0);
      @(posedge clk);
      {vm_en, vm_ren, vm_wr} <= 3'h7;
      @(posedge clk);
      vm_wr <= 1'b0;
    end
    fwc(OP_WRITE, LOCK_BYTE_ADDR, 16'h0400, 0, 1, 0, 1);
    chk("lock write", 8'h1, lwr);
    chk("lock eff", 8'hff, leff);
    rst(1'b0, 8'hfd);
    chk("lock eff", 8'hfd, leff);
    chk("flag", 8'h1, flag);
    fwc(OP_READ, 16'h0400, 16'h1000, 0, 0, 0, 0);
    fwc(OP_READ, 16'h0800, 16'h1000, 0, 0, 0, 1);
    fwc(OP_READ, 16'h0400, 16'h0000, 0, 0, 0, 1);
    dbc(OP_READ, 16'hf800, 0);
    fwc(OP_READ, 16'h0000, 16'h1000, 1, 0, 0, 1);
    fwc(OP_WRITE, LOCK_BYTE_ADDR, 16'h0000, 0, 1, 0, 0);
    fwc(OP_ERASE, 16'hf800, 16'h0000, 0, 1, 1, 0);
    ea_cnt = 0;
    @(posedge clk);
    dev_erase <= 1'b1;
    @(posedge clk);
    dev_erase <= 1'b0;
    host.post_irq();
    #1;
    chk("irq pending", 8'h1, ipend);
    chk("busy", 8'h1, busy);
    for (int i = 0; i < 200 && busy === 1'b1; i++) @(posedge clk);
    repeat (2) @(posedge clk);
    #1;
    chk("erase cycles", 8'd64, ea_cnt[7:0]);
    chk("lock eff", 8'hff, leff);
    // held interrupt released for service once the sweep ends
    chk("irq pending", 8'h0, ipend);
    repeat (4) @(posedge clk);
    #1;
    chk("sense idle", 8'h0, sense);
    host.fw(OP_READ, 16'h0100, 16'h0400, 0, 0, 0);
    seen = 0;
    repeat (3) begin
      #1;
      if (sense === 1'b1) seen = 1;
      @(posedge clk);
    end
    chk("sense pulse", 8'h1, seen[7:0]);
    fwc(OP_READ, 16'h0180, 16'h0400, 0, 0, 0, 1);
    chk("row change", 8'h1, rowc);
    fwc(OP_READ, 16'h01c0, 16'h0400, 0, 0, 0, 1);
    chk("row change", 8'h0, rowc);
    dbc(OP_WRITE, LOCK_BYTE_ADDR, 1);
    chk("lock write", 8'h1, lwr);
    @(posedge clk);
    skip <= 1'b1;
    host.fw(OP_READ, 16'h0100, 16'h0400, 0, 0, 0);
    @(posedge clk);
    #1;
    chk("sense bypass", 8'h1, sense);
    @(posedge clk);
    #1;
    chk("sense bypass end", 8'h0, sense);
    @(posedge clk);
    skip <= 1'b0;
    repeat (3) host.fw(OP_READ, 16'h0100, 16'h0400, 0, 0, 0);
    repeat (4) @(posedge clk);
    #1;
    chk("sense idle", 8'h0, sense);
    conclude();
  end
endmodule // testbench

// file: rtl/fag_one_shot.sv
// sense-amp enable one-shot with bypass
module fag_one_shot
  import fag_pkg::*;
(
  input  wire logic clk_in,
  input  wire logic srst_in,
  fag_os_if.shot    os
);
  logic [3:0] cnt_reg;
  logic [3:0] cnt_next;
  logic       en_reg;
  logic       en_next;

  always_comb begin
    cnt_next = cnt_reg;
    en_next  = en_reg;
    if (os.bypass) begin
      // bypassed: enable follows the access
      en_next  = os.access;
      cnt_next = 4'h0;
    end else if (os.access) begin
      en_next  = 1'b1;
      cnt_next = OS_CYCLES_W - 4'h1;
    end else if (cnt_reg != 4'h0) begin
      cnt_next = cnt_reg - 4'h1;
    end else begin
      en_next = 1'b0;
    end
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      cnt_reg <= 4'h0;
      en_reg  <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      en_reg  <= en_next;
    end
  end

  assign os.sense_en = en_reg;

  AST_OS_FIRE: assert property (@(posedge clk_in) disable iff (srst_in)
    os.access |=> en_reg) else $error("sense enable missing after access");
  AST_OS_BYPASS: assert property (@(posedge clk_in) disable iff (srst_in)
    os.bypass && !os.access |=> !en_reg) else $error("sense enable held in bypass");
endmodule // fag_one_shot

// file: rtl/fag_os_if.sv
// interface: access strobe to sense-amp one-shot
interface fag_os_if;
  logic access;
  logic bypass;
  logic sense_en;
  modport guard (output access, output bypass, input sense_en);
  modport shot  (input access, input bypass, output sense_en);
endinterface

// file: rtl/fag_pkg.sv
// package: constants and types for the flash access guard
package fag_pkg;
  localparam int          ADDR_W          = 16;
  localparam int          PAGE_BYTES      = 1024;
  localparam int          PAGE_SHIFT      = 10;
  localparam int          ROW_BYTES       = 128;
  localparam int          ROW_SHIFT       = 7;
  localparam int          NUM_PAGES       = 64;
  localparam logic [5:0]  LOCK_PAGE       = 6'h3e;
  localparam logic [15:0] LOCK_BYTE_ADDR  = 16'hfbff;
  localparam logic [5:0]  RSVD_PAGE       = 6'h3f;
  localparam logic [15:0] PART_ID_ADDR    = 16'hfffe;
  localparam logic [7:0]  LOCK_BYTE_ERASED = 8'hff;
  localparam int          OS_TIME_NS      = 20;
  localparam int          CLK_PERIOD_NS   = 10;
  localparam int          OS_CYCLES       = (OS_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [3:0]  OS_CYCLES_W     = 4'(OS_CYCLES);
  localparam int          OS_MAX_MHZ      = 10;
  typedef enum {ST_IDLE, ST_ERASE, ST_DONE} fag_state_t;
  typedef enum logic [1:0] {OP_READ = 2'h0, OP_WRITE = 2'h1, OP_ERASE = 2'h2} fag_op_t;
endpackage

// file: rtl/flash_access_guard.sv
// top: flash access protection guard
// Operation
// - reserved area refused to debug port; firmware access causes error reset
// - error reset sets flash error flag, reading 1 afterwards
// - debug device erase wipes pages 0 through the lock page, reserved page excluded, unlocking all
// - forbidden debug-port operations are ignored, never reset
// - any locked page also locks the lock-byte page
// - written lock byte is frozen until debug device erase
// - new lock byte takes effect only at next reset
// - scratchpad locked only when all other pages locked
// - device erase also erases scratchpad
// - part id byte readable at fixed code address
// - firmware modify with supply monitor or its enable off gives error reset
// - power-on reset turns supply monitor and its enable on
// - interrupts pending during flash operation stay pending
// - one-shot gives minimum sense enable per access
// - one-shot active after reset; skip bit bypasses it
// - flash organised in 128-byte rows; row change flagged
// - locked pages from zero equal ones complement of lock byte
// - erase needs write and erase enables; write needs write enable
// - protection and erase work on 1024-byte pages
module flash_access_guard
  import fag_pkg::*;
(
  input  wire logic        clk_in,
  input  wire logic        srst_in,
  input  wire logic        por_in,
  input  wire logic        fw_req_in,
  input  wire logic [1:0]  fw_op_in,
  input  wire logic [15:0] fw_addr_in,
  input  wire logic [15:0] fw_pc_in,
  input  wire logic        fw_scratch_in,
  input  wire logic        flash_write_enable_bit_in,
  input  wire logic        flash_erase_enable_bit_in,
  input  wire logic        vmon_en_in,
  input  wire logic        vmon_rst_en_in,
  input  wire logic        vmon_wr_in,
  input  wire logic        vmon_en_wr_in,
  input  wire logic        vmon_rst_en_wr_in,
  input  wire logic        dbg_req_in,
  input  wire logic [1:0]  dbg_op_in,
  input  wire logic [15:0] dbg_addr_in,
  input  wire logic        debug_port_device_erase_in,
  input  wire logic [7:0]  lock_byte_in,
  input  wire logic        skip_bit_in,
  input  wire logic        irq_in,
  input  wire logic        rst_src_wr_in,
  output logic             permit_out,
  output logic             dbg_permit_out,
  output logic             flash_error_reset_out,
  output logic             flash_error_flag_out,
  output logic             vmon_en_out,
  output logic             vmon_rst_en_out,
  output logic             page_erase_out,
  output logic             byte_write_out,
  output logic             erase_all_out,
  output logic             lock_wr_out,
  output logic             part_id_read_out,
  output logic             sense_en_out,
  output logic             row_change_out,
  output logic             irq_pending_out,
  output logic             busy_out,
  output logic [7:0]       lock_eff_out
);
  // ==========================================================
  // lock state
  logic [7:0]  lock_eff_reg;
  logic [7:0]  lock_eff_next;
  logic        lock_written_reg;
  logic        lock_written_next;
  logic [6:0]  nlocked;
  logic        any_locked;
  logic        all_locked;
  logic        vmon_en_reg;
  logic        vmon_en_next;
  logic        vmon_rst_en_reg;
  logic        vmon_rst_en_next;

  always_comb begin
    nlocked    = {1'b0, ~lock_eff_reg[5:0]} | (lock_eff_reg[7:6] != 2'h3 ? 7'h40 : 7'h00);
    any_locked = (lock_eff_reg != LOCK_BYTE_ERASED);
    all_locked = (nlocked >= 7'(LOCK_PAGE));
  end

  function automatic logic page_locked(input logic [15:0] a, input logic scr);
    logic [5:0] pg;
    pg = a[15:PAGE_SHIFT];
    if (scr) return all_locked;
    if (pg == LOCK_PAGE) return any_locked;
    return ({1'b0, pg} < nlocked);
  endfunction

  // ==========================================================
  // decisions
  logic        fw_modify;
  logic        fw_bad;
  logic        dbg_ok;
  logic        tgt_lk;
  logic        pc_lk;
  logic        erase_op;
  logic        write_op;
  always_comb begin
    erase_op  = fw_op_in == OP_ERASE;
    write_op  = fw_op_in == OP_WRITE;
    tgt_lk    = page_locked(fw_addr_in, fw_scratch_in);
    pc_lk     = page_locked(fw_pc_in, 1'b0);
    fw_modify = fw_req_in && (erase_op || write_op);
    fw_bad    = 1'b0;
    if (fw_req_in) begin
      if (!fw_scratch_in && fw_addr_in[15:PAGE_SHIFT] == RSVD_PAGE
          && !(fw_op_in == OP_READ && fw_addr_in == PART_ID_ADDR))
        fw_bad = 1'b1;
      if (tgt_lk && !pc_lk) fw_bad = 1'b1;
      if (erase_op && !fw_scratch_in && fw_addr_in[15:PAGE_SHIFT] == LOCK_PAGE)
        fw_bad = 1'b1;
      if (write_op && !fw_scratch_in && fw_addr_in == LOCK_BYTE_ADDR && lock_written_reg)
        fw_bad = 1'b1;
      if (fw_modify && !(vmon_en_reg && vmon_rst_en_reg)) fw_bad = 1'b1;
      if (erase_op && !(flash_write_enable_bit_in && flash_erase_enable_bit_in))
        fw_bad = 1'b1;
      if (write_op && !flash_write_enable_bit_in) fw_bad = 1'b1;
    end
    dbg_ok = dbg_req_in && dbg_addr_in[15:PAGE_SHIFT] != RSVD_PAGE
             && !page_locked(dbg_addr_in, 1'b0)
             && !(dbg_op_in == OP_ERASE && dbg_addr_in[15:PAGE_SHIFT] == LOCK_PAGE && any_locked)
             && !(dbg_op_in == OP_WRITE && dbg_addr_in == LOCK_BYTE_ADDR && lock_written_reg);
  end

  // ==========================================================
  // supply monitor enables and error flag
  logic        ferr_reg;
  logic        ferr_next;
  logic        flash_error_reset_reg;
  logic        flash_error_reset_next;
  always_comb begin
    vmon_en_next     = vmon_en_reg;
    vmon_rst_en_next = vmon_rst_en_reg;
    if (vmon_en_wr_in) vmon_en_next = vmon_en_in;
    if (vmon_rst_en_wr_in) vmon_rst_en_next = vmon_rst_en_in;
    if (vmon_wr_in) begin
      vmon_en_next     = vmon_en_in;
      vmon_rst_en_next = vmon_rst_en_in;
    end
    ferr_next = ferr_reg;
    if (rst_src_wr_in) ferr_next = 1'b0;
    flash_error_reset_next = fw_bad;
    if (fw_bad) ferr_next = 1'b1;
  end

  // ==========================================================
  // erase sequencer and lock capture
  fag_state_t  st_reg;
  fag_state_t  st_next;
  logic [5:0]  pg_reg;
  logic [5:0]  pg_next;
  logic        pe_reg;
  logic        pe_next;
  logic        bw_reg;
  logic        bw_next;
  logic        ea_reg;
  logic        ea_next;
  logic        lw_reg;
  logic        lw_next;
  logic        pid_reg;
  logic        pid_next;
  logic        dp_reg;
  logic        dp_next;
  logic        pm_reg;
  logic        pm_next;
  logic        irq_reg;
  logic        irq_next;
  logic [8:0]  row_reg;
  logic [8:0]  row_next;
  logic        rc_reg;
  logic        rc_next;
  logic        busy_reg;
  logic        busy_next;
  always_comb begin
    st_next = st_reg;
    pg_next = pg_reg;
    ea_next = 1'b0;
    lock_eff_next     = lock_eff_reg;
    lock_written_next = lock_written_reg;
    pm_next  = fw_req_in && !fw_bad;
    dp_next  = dbg_ok;
    pe_next  = fw_req_in && !fw_bad && erase_op;
    bw_next  = fw_req_in && !fw_bad && write_op;
    lw_next  = 1'b0;
    pid_next = fw_req_in && fw_op_in == OP_READ && fw_addr_in == PART_ID_ADDR;
    if (fw_req_in && !fw_bad && write_op && !fw_scratch_in && fw_addr_in == LOCK_BYTE_ADDR) begin
      lw_next = 1'b1;
      lock_written_next = 1'b1;
    end
    if (dbg_ok && dbg_op_in == OP_WRITE && dbg_addr_in == LOCK_BYTE_ADDR) begin
      lw_next = 1'b1;
      lock_written_next = 1'b1;
    end
    case (st_reg)
      ST_IDLE: begin
        if (debug_port_device_erase_in) begin
          st_next = ST_ERASE;
          pg_next = 6'h00;
        end
      end
      ST_ERASE: begin
        ea_next = 1'b1;
        pg_next = pg_reg + 6'h01;
        if (pg_reg == LOCK_PAGE) st_next = ST_DONE;
      end
      ST_DONE: begin
        ea_next = 1'b1; // scratchpad pass
        lock_eff_next     = LOCK_BYTE_ERASED;
        lock_written_next = 1'b0;
        st_next = ST_IDLE;
      end
      default: st_next = ST_IDLE;
    endcase
    irq_next = (irq_reg || irq_in) && (fw_modify || st_reg != ST_IDLE || irq_in);
    row_next = fw_req_in ? fw_addr_in[15:ROW_SHIFT] : row_reg;
    rc_next  = fw_req_in && fw_addr_in[15:ROW_SHIFT] != row_reg;
    busy_next = st_next != ST_IDLE;
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      lock_eff_reg     <= lock_byte_in;
      lock_written_reg <= lock_byte_in != LOCK_BYTE_ERASED;
      st_reg  <= ST_IDLE;
      pg_reg  <= 6'h00;
      pe_reg  <= 1'b0;
      bw_reg  <= 1'b0;
      ea_reg  <= 1'b0;
      lw_reg  <= 1'b0;
      pid_reg <= 1'b0;
      dp_reg  <= 1'b0;
      pm_reg  <= 1'b0;
      irq_reg <= 1'b0;
      row_reg <= 9'h000;
      rc_reg  <= 1'b0;
      busy_reg <= 1'b0;
      flash_error_reset_reg <= 1'b0;
      if (por_in) begin
        vmon_en_reg     <= 1'b1;
        vmon_rst_en_reg <= 1'b1;
        ferr_reg        <= 1'b0;
      end else begin
        ferr_reg <= ferr_reg | flash_error_reset_reg;
      end
    end else begin
      lock_eff_reg     <= lock_eff_next;
      lock_written_reg <= lock_written_next;
      st_reg  <= st_next;
      pg_reg  <= pg_next;
      pe_reg  <= pe_next;
      bw_reg  <= bw_next;
      ea_reg  <= ea_next;
      lw_reg  <= lw_next;
      pid_reg <= pid_next;
      dp_reg  <= dp_next;
      pm_reg  <= pm_next;
      irq_reg <= irq_next;
      row_reg <= row_next;
      rc_reg  <= rc_next;
      busy_reg <= busy_next;
      flash_error_reset_reg <= flash_error_reset_next;
      vmon_en_reg     <= vmon_en_next;
      vmon_rst_en_reg <= vmon_rst_en_next;
      ferr_reg        <= ferr_next;
    end
  end

  // ==========================================================
  // one-shot
  fag_os_if os_if ();
  logic se_reg;
  assign os_if.access = fw_req_in || dbg_req_in;
  assign os_if.bypass = skip_bit_in;
  fag_one_shot u_os (.clk_in(clk_in), .srst_in(srst_in), .os(os_if.shot));
  always_ff @(posedge clk_in) begin
    if (srst_in) se_reg <= 1'b0;
    else se_reg <= os_if.sense_en;
  end

  assign permit_out            = pm_reg;
  assign dbg_permit_out        = dp_reg;
  assign flash_error_reset_out = flash_error_reset_reg;
  assign flash_error_flag_out  = ferr_reg;
  assign vmon_en_out           = vmon_en_reg;
  assign vmon_rst_en_out       = vmon_rst_en_reg;
  assign page_erase_out        = pe_reg;
  assign byte_write_out        = bw_reg;
  assign erase_all_out         = ea_reg;
  assign lock_wr_out           = lw_reg;
  assign part_id_read_out      = pid_reg;
  assign sense_en_out          = se_reg;
  assign row_change_out        = rc_reg;
  assign irq_pending_out       = irq_reg;
  assign busy_out              = busy_reg;
  assign lock_eff_out          = lock_eff_reg;

  AST_RSVD_FLASH_ERROR_RESET: assert property (@(posedge clk_in) disable iff (srst_in)
    fw_req_in && !fw_scratch_in && fw_addr_in[15:10] == RSVD_PAGE
    && !(fw_op_in == OP_READ && fw_addr_in == PART_ID_ADDR) |=> flash_error_reset_reg)
    else $error("reserved access without error reset");
  AST_FLAG_SET: assert property (@(posedge clk_in) disable iff (srst_in)
    fw_bad |=> ferr_reg) else $error("error flag not set");
  AST_DBG_NORST: assert property (@(posedge clk_in) disable iff (srst_in)
    !fw_req_in |=> !flash_error_reset_reg) else $error("debug access caused reset");
  AST_ERASE_UNLOCK: assert property (@(posedge clk_in) disable iff (srst_in)
    st_reg == ST_DONE |=> lock_eff_reg == 8'hff && !lock_written_reg)
    else $error("device erase left lock");
  AST_LOCKPG: assert property (@(posedge clk_in) disable iff (srst_in)
    any_locked |-> page_locked(LOCK_BYTE_ADDR, 1'b0)) else $error("lock page open");
  AST_LOCK_HOLD: assert property (@(posedge clk_in) disable iff (srst_in)
    st_reg != ST_DONE |=> $stable(lock_eff_reg)) else $error("lock changed early");
  AST_VMON: assert property (@(posedge clk_in) disable iff (srst_in)
    fw_modify && !vmon_en_reg |=> flash_error_reset_reg) else $error("monitor off modify allowed");
  AST_ERASE_EN: assert property (@(posedge clk_in) disable iff (srst_in)
    page_erase_out |-> $past(flash_erase_enable_bit_in) && $past(flash_write_enable_bit_in))
    else $error("erase without enables");
  AST_SCR: assert property (@(posedge clk_in) disable iff (srst_in)
    !all_locked |-> !page_locked(16'h0000, 1'b1)) else $error("scratchpad locked");

  // ==========================================================
  // reset, refusal and sweep checks
  AST_FLAG_KEEP: assert property (@(posedge clk_in)
    srst_in && !por_in && (ferr_reg || flash_error_reset_reg) |=> ferr_reg)
    else $error("error flag lost in reset");
  AST_POR_VMON: assert property (@(posedge clk_in)
    srst_in && por_in |=> vmon_en_reg && vmon_rst_en_reg)
    else $error("monitor enables off after power-on reset");
  AST_DBG_RSVD: assert property (@(posedge clk_in) disable iff (srst_in)
    dbg_req_in && dbg_addr_in[15:10] == RSVD_PAGE |=> !dp_reg)
    else $error("reserved area open to debug port");
  AST_SWEEP_END: assert property (@(posedge clk_in) disable iff (srst_in)
    st_reg == ST_DONE |=> ea_reg) else $error("scratchpad pass missing");
  AST_WRITE_EN: assert property (@(posedge clk_in) disable iff (srst_in)
    byte_write_out |-> $past(flash_write_enable_bit_in))
    else $error("write without enable");
  AST_PID_READ: assert property (@(posedge clk_in) disable iff (srst_in)
    fw_req_in && fw_op_in == OP_READ && fw_addr_in == PART_ID_ADDR && !(tgt_lk && !pc_lk)
    |=> !flash_error_reset_reg) else $error("part id read refused");
endmodule // flash_access_guard
